// ==== rtl/stp_pkg.sv ====
// constants, types and helpers shared by the serial transmitter
// Function
// - even parity bit is the xor of all data bits
// - odd parity inverts that xor before sending
// - parity bit sits after last data bit, before first stop bit
// - while transmit enable is set the block owns the serial output pin
// - synchronous mode shifts on the serial clock pin
// - writing the data location loads the buffer and starts sending
// - buffer moves to shifter when idle or right after last stop bit
// - a loaded shifter sends one whole frame at the selected bit rate
// - unused upper data bits are ignored for short characters
// - nine-bit characters take bit eight from the ninth-bit control
// - buffer-empty flag set when buffer empty, clear while it holds data
// - buffer-empty request stays high while flag set and enabled
// - any data write clears the buffer-empty flag
// - complete flag sets when frame done and buffer empty
// - complete flag clears on interrupt service or written one
// - complete request rises with the complete flag when enabled
// - disabling waits for pending data, then releases the pin
// - low start, data lsb first, optional parity, high stops, idle high
// - baud tick divided by 16, 8 double speed, 2 synchronous master
// - polarity zero changes data on rising clock, one on falling
package stp_pkg;
  localparam int AW = 8;
  localparam logic [AW-1:0] A_DATA = 8'h00;
  localparam logic [AW-1:0] A_STAT = 8'h04;
  localparam logic [AW-1:0] A_CTRL = 8'h08;
  localparam logic [AW-1:0] A_FMT = 8'h0c;
  localparam logic [AW-1:0] A_BAUD = 8'h10;
  localparam int STAT_UDRE = 0;
  localparam int STAT_TXC = 1;
  localparam int STAT_DBL = 2;
  localparam int STAT_BUSY = 3;
  localparam int BAUD_W = 12;
  localparam int DIV_NORM = 16;
  localparam int DIV_DBL = 8;
  localparam int FRAME_W = 13;
  localparam int CHAR_MAX = 9;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;

  typedef struct packed {
    logic pol;
    logic master;
    logic sync;
    logic stop2;
    logic [1:0] par;
    logic [2:0] size;
  } stp_fmt_t;
  localparam int FMT_W = 9;
  localparam stp_fmt_t RST_FMT = 9'h003;

  typedef struct packed {
    logic txc_ie;
    logic udr_ie;
    logic ninth;
    logic en;
  } stp_ctrl_t;
  localparam int CTRL_W = 4;
  localparam stp_ctrl_t RST_CTRL = 4'h0;
  localparam logic [BAUD_W-1:0] RST_BAUD = 12'h000;

  // size codes 0..3 give 5..8 bits, the nine code gives 9, reserved codes act as 8
  function automatic logic [3:0] stp_char_bits(input logic [2:0] code);
    logic [3:0] n;
    n = 4'h8;
    if (code == SIZE_NINE) n = 4'h9;
    else if (code < 3'h4) n = 4'(code) + 4'h5;
    return n;
  endfunction
endpackage

// ==== rtl/stp_parity.sv ====
// parity over the active data bits of one character
`timescale 1ns/1ps
`default_nettype none
module stp_parity (
  input wire logic [stp_pkg::CHAR_MAX-1:0] data,
  input wire logic [3:0] nbits,
  input wire logic odd,
  output logic parity
);
  import stp_pkg::*;
  logic [CHAR_MAX-1:0] masked;
  always_comb begin
    for (int i = 0; i < CHAR_MAX; i++) begin
      masked[i] = (i < int'(nbits)) ? data[i] : 1'b0;
    end
    parity = (^masked) ^ odd;
  end
endmodule
`default_nettype wire

// ==== rtl/stp_bitclk.sv ====
// baud generator and bit tick selection for the transmitter
`timescale 1ns/1ps
`default_nettype none
module stp_bitclk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [stp_pkg::BAUD_W-1:0] divisor,
  input wire logic reload,
  input wire logic dbl,
  input wire stp_pkg::stp_fmt_t fmt,
  input wire logic xck_pin,
  output logic xck,
  output logic bit_tick
);
  import stp_pkg::*;
  logic [BAUD_W-1:0] cnt;
  logic [3:0] pre;
  logic [3:0] pre_last;
  logic bg_tick;
  logic s1, s2, s3, lvl;
  logic a_tick, m_tick, s_tick;

  assign bg_tick = (cnt == '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= '0;
    else if (reload || bg_tick) cnt <= divisor;
    else cnt <= cnt - 1'b1;
  end

  assign pre_last = dbl ? 4'(DIV_DBL - 1) : 4'(DIV_NORM - 1);
  assign a_tick = bg_tick && (pre == pre_last);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pre <= '0;
    else if (a_tick || fmt.sync) pre <= '0;
    else if (bg_tick) pre <= pre + 1'b1;
  end

  // master clock toggles per baud tick: one bit per two ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) xck <= 1'b0;
    else if (fmt.sync && fmt.master && bg_tick) xck <= !xck;
    else if (!(fmt.sync && fmt.master)) xck <= 1'b0;
  end
  assign m_tick = bg_tick && (fmt.pol ? xck : !xck);

  // slave clock: three stages, a change counts when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      lvl <= 1'b0;
    end else begin
      s1 <= xck_pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) lvl <= s3;
    end
  end
  assign s_tick = (s2 == s3) && (s3 != lvl) && (fmt.pol ? !s3 : s3);

  assign bit_tick = fmt.sync ? (fmt.master ? m_tick : s_tick) : a_tick;
endmodule
`default_nettype wire

// ==== rtl/stp_tx.sv ====
// serial transmitter with one-entry buffer, parity and apb registers
`timescale 1ns/1ps
`default_nettype none
module stp_tx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [stp_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txc_irq_ack,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  output logic serial_out_pin,
  output logic serial_out_pin_oe,
  output logic buffer_empty_irq,
  output logic tx_complete_irq
);
  import stp_pkg::*;

  typedef enum logic {ST_IDLE, ST_SEND} stp_state_t;

  stp_state_t state;
  stp_fmt_t fmt;
  stp_ctrl_t ctrl;
  logic dbl;
  logic [BAUD_W-1:0] baud;
  logic [CHAR_MAX-1:0] tx_buf;
  logic buf_full;
  logic txc;
  logic [FRAME_W-1:0] sr;
  logic [3:0] left;

  logic wr, setup, hit;
  logic [31:0] rdata;
  logic data_wr, baud_wr, txc_clr;
  logic bit_tick;
  logic par_bit;
  logic [3:0] nbits, flen;
  logic [FRAME_W-1:0] frame;
  logic frame_end, idle_load, chain_load, load, txc_set;

  // ---------------- apb slave ----------------
  // one wait state: pready rises in the second access cycle
  assign setup = psel && penable && !pready;
  assign wr = psel && penable && pready && pwrite;

  always_comb begin
    case (paddr)
      A_DATA, A_STAT, A_CTRL, A_FMT, A_BAUD: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    rdata = '0;
    case (paddr)
      A_STAT: begin
        rdata[STAT_UDRE] = !buf_full;
        rdata[STAT_TXC] = txc;
        rdata[STAT_DBL] = dbl;
        rdata[STAT_BUSY] = (state == ST_SEND);
      end
      A_CTRL: rdata[CTRL_W-1:0] = ctrl;
      A_FMT: rdata[FMT_W-1:0] = fmt;
      A_BAUD: rdata[BAUD_W-1:0] = baud;
      default: rdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit;
      if (setup) prdata <= pwrite ? 32'h0 : rdata;
    end
  end

  assign data_wr = wr && (paddr == A_DATA);
  assign baud_wr = wr && (paddr == A_BAUD);
  // the buffer-empty position is read-only; software writes zero there
  assign txc_clr = (wr && (paddr == A_STAT) && pwdata[STAT_TXC]) || txc_irq_ack;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= RST_CTRL;
      fmt <= RST_FMT;
      dbl <= 1'b0;
      baud <= RST_BAUD;
    end else if (wr) begin
      case (paddr)
        A_CTRL: ctrl <= pwdata[CTRL_W-1:0];
        A_FMT: fmt <= pwdata[FMT_W-1:0];
        A_STAT: dbl <= pwdata[STAT_DBL];
        A_BAUD: baud <= pwdata[BAUD_W-1:0];
        default: ;
      endcase
    end
  end

  // ---------------- bit timing ----------------
  stp_bitclk u_bitclk (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(baud),
    .reload(baud_wr),
    .dbl(dbl),
    .fmt(fmt),
    .xck_pin(serial_clock_pin_in),
    .xck(serial_clock_pin_out),
    .bit_tick(bit_tick)
  );

  // ---------------- frame assembly ----------------
  assign nbits = stp_char_bits(fmt.size);

  stp_parity u_parity (
    .data(tx_buf),
    .nbits(nbits),
    .odd(fmt.par == PAR_ODD),
    .parity(par_bit)
  );

  always_comb begin
    frame = '1; // stop bits and unused tail stay high
    frame[0] = 1'b0;
    for (int i = 0; i < CHAR_MAX; i++) begin
      if (i < int'(nbits)) frame[1 + i] = tx_buf[i];
    end
    if (fmt.par[1]) frame[4'h1 + nbits] = par_bit;
    flen = 4'h2 + nbits + {3'h0, fmt.par[1]} + {3'h0, fmt.stop2};
  end

  // ---------------- shifter ----------------
  // left counts bits still to put on the line; at zero the last stop bit has run a
  // full bit time, which is the point where a waiting character may follow directly
  assign frame_end = bit_tick && (state == ST_SEND) && (left == 4'h0);
  assign idle_load = (state == ST_IDLE) && buf_full && ctrl.en;
  assign chain_load = frame_end && buf_full;
  assign load = idle_load || chain_load;
  assign txc_set = frame_end && !buf_full;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      sr <= '1;
      left <= '0;
      serial_out_pin <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          serial_out_pin <= 1'b1;
          if (idle_load) begin
            state <= ST_SEND;
            sr <= frame;
            left <= flen;
          end
        end
        ST_SEND: begin
          if (bit_tick) begin
            if (left != 4'h0) begin
              serial_out_pin <= sr[0];
              sr <= {1'b1, sr[FRAME_W-1:1]};
              left <= left - 4'h1;
            end else if (buf_full) begin
              // back to back: the next start bit follows the last stop bit
              serial_out_pin <= frame[0];
              sr <= {1'b1, frame[FRAME_W-1:1]};
              left <= flen - 4'h1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ---------------- buffer and flags ----------------
  // a write in the cycle of a load keeps the buffer full with the new character
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_full <= 1'b0;
      tx_buf <= '0;
    end else if (data_wr) begin
      buf_full <= 1'b1;
      tx_buf <= {ctrl.ninth, pwdata[7:0]};
    end else if (load) begin
      buf_full <= 1'b0;
    end
  end

  // set wins over both clear sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) txc <= 1'b0;
    else if (txc_set) txc <= 1'b1;
    else if (txc_clr) txc <= 1'b0;
  end

  // ---------------- pins and requests ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin_oe <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      buffer_empty_irq <= 1'b0;
      tx_complete_irq <= 1'b0;
    end else begin
      // pending data keeps the pin owned after enable is cleared
      serial_out_pin_oe <= ctrl.en || (state == ST_SEND);
      serial_clock_pin_oe <= fmt.sync && fmt.master && (ctrl.en || state == ST_SEND);
      buffer_empty_irq <= !buf_full && ctrl.udr_ie;
      tx_complete_irq <= txc && ctrl.txc_ie;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_even_parity: assert property (load && fmt.par == PAR_EVEN |->
    frame[4'h1 + nbits] == ^(tx_buf & 9'((10'h1 << nbits) - 10'h1)))
    else $error("even parity bit wrong");

  a_odd_parity: assert property (load && fmt.par == PAR_ODD |->
    frame[4'h1 + nbits] != ^(tx_buf & 9'((10'h1 << nbits) - 10'h1)))
    else $error("odd parity bit wrong");

  a_frame_length: assert property (idle_load |=> left == 4'h2 + nbits
    + {3'h0, fmt.par[1]} + {3'h0, fmt.stop2})
    else $error("frame length does not hold parity and stops");

  a_pin_owned: assert property (ctrl.en |=> serial_out_pin_oe)
    else $error("output pin not owned while enabled");

  a_data_write: assert property (data_wr |=> buf_full && !rdata[STAT_UDRE] || paddr != A_STAT)
    else $error("data write did not fill buffer");

  a_chain_start: assert property (chain_load |=> state == ST_SEND && !serial_out_pin)
    else $error("queued character did not follow directly");

  a_ninth_bit: assert property (load && fmt.size == SIZE_NINE |-> frame[9] == tx_buf[8])
    else $error("ninth bit not taken from control");

  a_udre_request: assert property ((!buf_full && ctrl.udr_ie)[*2] |-> buffer_empty_irq)
    else $error("buffer-empty request missing");

  a_txc_set: assert property (txc_set |=> txc ##1 tx_complete_irq || !ctrl.txc_ie)
    else $error("complete flag or request missing");

  a_txc_clear: assert property (txc_irq_ack && !txc_set |=> !txc)
    else $error("complete flag not cleared by service");

  a_txc_request: assert property ($rose(txc) && ctrl.txc_ie |=> tx_complete_irq)
    else $error("complete request did not follow flag");

  a_disable_wait: assert property (!ctrl.en && state == ST_SEND |=> serial_out_pin_oe)
    else $error("pin released before frame ended");

  a_idle_high: assert property (state == ST_IDLE && $past(state) == ST_IDLE |-> serial_out_pin)
    else $error("idle line not high");

  a_stop_high: assert property (frame_end |-> serial_out_pin)
    else $error("last bit of frame not high");
endmodule
`default_nettype wire

// ==== bench/stp_rx_model.sv ====
// far-end receiver model that samples the serial line in mid-bit
`timescale 1ns/1ps
`default_nettype none
module stp_rx_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic line,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  input wire logic [15:0] per,
  output logic [8:0] rx_data,
  output logic rx_par,
  output logic rx_stop,
  output logic [7:0] rx_cnt
);
  int i;
  initial begin
    rx_data = '0;
    rx_par = 1'b0;
    rx_stop = 1'b0;
    rx_cnt = 8'h00;
    forever begin
      @(posedge pclk);
      if (presetn === 1'b1 && line === 1'b0) begin
        // mid-bit sampling tolerates the one-cycle edge offset of detection
        repeat (per >> 1) @(posedge pclk);
        for (i = 0; i < 9; i++) begin
          rx_data[i] = 1'b0;
          if (i < nbits) begin
            repeat (per) @(posedge pclk);
            rx_data[i] = line;
          end
        end
        if (par_en) begin
          repeat (per) @(posedge pclk);
          rx_par = line;
        end
        repeat (per) @(posedge pclk);
        rx_stop = line;
        rx_cnt = rx_cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/stp_tx_tb_top.sv ====
// self-checking testbench for the serial transmitter
`timescale 1ns/1ps
`default_nettype none
module stp_tx_tb_top;
  import stp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ack = 0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, so, so_oe, be_irq, tc_irq, rx_par, rx_stop, m_par = 0;
  logic [3:0] m_bits = 4'h8, nb;
  logic [15:0] m_per = 16'h0020;
  logic [8:0] rx_data, d, d2;
  logic [7:0] rx_cnt, c0;
  logic [2:0] sz;
  logic xk = 0, xk_run = 0, cko, cko_oe, ck0;
  logic [1:0] pm;
  int miscompares = 0, n_compared = 0, k;

  stp_tx i_stp_tx (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txc_irq_ack(ack), .serial_clock_pin_in(xk),
    .serial_clock_pin_out(cko), .serial_clock_pin_oe(cko_oe), .serial_out_pin(so),
    .serial_out_pin_oe(so_oe), .buffer_empty_irq(be_irq), .tx_complete_irq(tc_irq));
  stp_rx_model i_stp_rx_model (.pclk(pclk), .presetn(presetn), .line(so), .nbits(m_bits),
    .par_en(m_par), .per(m_per), .rx_data(rx_data), .rx_par(rx_par), .rx_stop(rx_stop),
    .rx_cnt(rx_cnt));

  initial begin
    forever #5 pclk = ~pclk;
  end

  // external serial clock for slave mode: one rising edge every 16 cycles, still when idle
  initial begin
    forever begin
      repeat (8) @(posedge pclk);
      if (xk_run) xk <= ~xk;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(0, 1, "no pready");
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  function automatic logic parity(input logic [8:0] v, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int j = 0; j < 9; j++) if (j < n) p ^= v[j];
    return p;
  endfunction

  task automatic wait_frame(input logic [7:0] c);
    int n;
    n = 0;
    while (rx_cnt === c && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    if (rx_cnt === c) chk(0, 1, "no frame");
  endtask

  task close_out;
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    k = $urandom(32'hd348f968);
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, A_STAT, 0);
    chk(rd, 32'h1, "stat reset");
    apb(0, A_FMT, 0);
    chk(rd, 32'h3, "fmt reset");
    chk(so_oe, 0, "pin owned at reset");
    apb(0, 8'h20, 0);
    chk(er, 1, "unmapped");
    apb(1, A_BAUD, 32'h1);
    apb(1, A_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    chk(so_oe, 1, "pin taken");
    chk(so, 1, "idle level");
    $display("test reset done");
    // size codes 0..3 and the nine code against no, even and odd parity, format changed only while idle
    for (k = 0; k < 15; k++) begin
      sz = (k / 3 == 4) ? SIZE_NINE : 3'(k / 3);
      pm = (k % 3 == 0) ? 2'h0 : 2'(k % 3 + 1);
      nb = (sz == SIZE_NINE) ? 4'h9 : 4'(sz) + 4'h5;
      d = 9'($urandom);
      apb(1, A_FMT, 32'({1'($urandom), pm, sz}));
      apb(1, A_CTRL, 32'({d[8], 1'b1}));
      m_bits <= nb;
      m_par <= pm[1];
      c0 = rx_cnt;
      apb(1, A_DATA, 32'(d[7:0]));
      wait_frame(c0);
      chk(rx_data, d & ((9'h1 << nb) - 9'h1), "data");
      if (pm[1]) chk(rx_par, parity(d, nb, pm[0]), "parity");
      chk(rx_stop, 1, "stop");
      repeat (80) @(posedge pclk);
      apb(0, A_STAT, 0);
      chk(rd[1:0], 2'h3, "complete");
      apb(1, A_STAT, 32'h2);
      apb(0, A_STAT, 0);
      chk(rd[1], 0, "w1c");
    end
    $display("test formats done");
    apb(1, A_FMT, 32'h3);
    m_bits <= 4'h8;
    m_par <= 0;
    m_per <= 16'h0010;
    apb(1, A_STAT, 32'h4);
    apb(1, A_CTRL, 32'hd);
    // the request is registered one cycle behind the enable write
    repeat (2) @(posedge pclk);
    chk(be_irq, 1, "empty irq");
    d = 9'($urandom);
    d2 = 9'($urandom);
    c0 = rx_cnt;
    apb(1, A_DATA, 32'(d[7:0]));
    apb(1, A_DATA, 32'(d2[7:0]));
    apb(0, A_STAT, 0);
    chk(rd[0], 0, "buffer held");
    chk(be_irq, 0, "empty irq off");
    wait_frame(c0);
    chk(rx_data[7:0], d[7:0], "first");
    c0 = rx_cnt;
    wait_frame(c0);
    chk(rx_data[7:0], d2[7:0], "second");
    repeat (40) @(posedge pclk);
    chk(tc_irq, 1, "complete irq");
    ack <= 1;
    @(posedge pclk);
    ack <= 0;
    repeat (3) @(posedge pclk);
    chk(tc_irq, 0, "serviced");
    $display("test irq done");
    c0 = rx_cnt;
    apb(1, A_DATA, 32'h5a);
    apb(1, A_CTRL, 32'h0);
    chk(so_oe, 1, "pin held");
    wait_frame(c0);
    chk(rx_data[7:0], 8'h5a, "last frame");
    repeat (20) @(posedge pclk);
    chk(so_oe, 0, "pin released");
    $display("test disable done");
    apb(1, A_CTRL, 32'h1);
    apb(1, A_FMT, 32'hc3);
    m_per <= 16'h0004;
    repeat (4) @(posedge pclk);
    chk(cko_oe, 1, "clock pin driven");
    ck0 = cko;
    repeat (2) @(posedge pclk);
    chk(cko, !ck0, "master clock");
    d = 9'($urandom);
    c0 = rx_cnt;
    apb(1, A_DATA, 32'(d[7:0]));
    wait_frame(c0);
    chk(rx_data[7:0], d[7:0], "sync master");
    repeat (20) @(posedge pclk);
    apb(1, A_FMT, 32'h43);
    m_per <= 16'h0010;
    xk_run <= 1;
    d = 9'($urandom);
    c0 = rx_cnt;
    apb(1, A_DATA, 32'(d[7:0]));
    wait_frame(c0);
    chk(rx_data[7:0], d[7:0], "sync slave");
    chk(cko_oe, 0, "clock pin free");
    xk_run <= 0;
    $display("test sync done");
    close_out;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    close_out;
  end
endmodule
`default_nettype wire
